// *** bench/adc_link_assertions.sv ***
`timescale 1ns/1ps
module adc_link_assertions
  import adc_link_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cal_dev_out,
  input wire logic cal_dev_oe,
  input wire logic cal_host_oe,
  input wire logic calibration_reset_low,
  input wire logic [adc_link_pkg::SAMPLE_W-1:0] sample_data,
  input wire logic output_clock,
  input wire logic over_range_p,
  input wire logic over_range_n,
  input wire logic [1:0] output_mode
);
  // ----------------
  // Link checks
  // ----------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Device outputs react three edges late, so allow a short grace
  wire logic line_low = !calibration_reset_low;

  a_clk_held_low: assert property (line_low [*4] |-> !output_clock)
    else $error("output clock runs while line low");
  a_or_line_low: assert property (line_low [*4] |-> over_range_p)
    else $error("over-range low while line low");
  a_or_cal_hold: assert property ($rose(calibration_reset_low) |-> over_range_p [*8])
    else $error("over-range dropped early in calibration");
  a_clk_resumes: assert property ($rose(calibration_reset_low) |-> ##[1:8] output_clock)
    else $error("output clock did not resume");
  a_data_on_edge: assert property ($changed(sample_data) |-> $changed(output_clock))
    else $error("data moved without a clock edge");
  a_clk_keeps_ddr: assert property (calibration_reset_low [*6] ##0 $stable(output_clock) [*2]
    |=> $changed(output_clock))
    else $error("output clock stalled while running");
  a_line_open_drain: assert property (cal_dev_oe |-> !cal_dev_out)
    else $error("device drives line high");
  a_recal_min_low: assert property ($rose(cal_host_oe) |-> cal_host_oe [*4])
    else $error("recalibration pull too short");
  a_or_pair_form: assert property ($stable(output_mode) |->
    (output_mode == MODE_CMOS ? !over_range_n : over_range_n != over_range_p))
    else $error("over-range pair form wrong");
  a_mode_legal: assert property (output_mode != 2'h3)
    else $error("illegal output mode");

  // Main scenarios reached
  c_recal: cover property ($rose(cal_host_oe));
  c_cmos: cover property (output_mode == MODE_CMOS);
  c_lvds2: cover property (output_mode == MODE_LVDS_2MA);
endmodule // adc_link_assertions

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import adc_link_pkg::*;
  // ----------------
  // Signals
  // ----------------
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, calibrating, init_done;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, divider_strap, output_mode_strap, sp_mode;
  logic [2:0] hsize;
  logic [11:0] analog_a, analog_b, pa;
  logic over_a, over_b, sp_div_override, sp_div_by2, sp_mode_override, sp_recal;
  logic [7:0] sp_gain_b, sp_offset_b;
  logic [1:0] sp_skew_b;
  logic pclk, pov, pc, w, lw, ov, ovf;
  logic [24:0] q[$];
  logic [24:0] e;
  int errors = 0;
  int samples_checked = 0;
  int skip, gap, exp_div, pb;
  int hb[5];

  adc_link_if lk ();
  adc_device_end #(.POR_CYCLES(4), .CAL_CYCLES(32)) adc_device_end_i (.hclk, .hresetn,
    .link(lk), .analog_a, .analog_b, .over_a, .over_b, .divider_strap, .output_mode_strap,
    .sp_div_override, .sp_div_by2, .sp_mode_override, .sp_mode, .sp_recal, .sp_gain_b,
    .sp_offset_b, .sp_skew_b, .calibrating, .init_done);
  adc_capture_end adc_capture_end_i (.hclk, .hresetn, .link(lk), .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata);
  adc_link_assertions adc_link_assertions_i (.hclk, .hresetn, .cal_dev_out(lk.cal_dev_out),
    .cal_dev_oe(lk.cal_dev_oe), .cal_host_oe(lk.cal_host_oe),
    .calibration_reset_low(lk.calibration_reset_low), .sample_data(lk.sample_data),
    .output_clock(lk.output_clock), .over_range_p(lk.over_range_p),
    .over_range_n(lk.over_range_n), .output_mode(lk.output_mode));

  // ----------------
  // Tasks
  // ----------------
  task chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task stop_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Single word transfer; waits only on hready, bounded
  task ahb(input logic wr, input logic [31:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= HTRANS_NONSEQ;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
    r = hrdata;
    if (n >= 100) begin errors++; stop_test(); end
  endtask
  task wcal(input logic v);
    int n;
    n = 0;
    do begin @(negedge hclk); n++; end while (calibrating !== v && n < 900);
    if (calibrating !== v) begin errors++; stop_test(); end
    @(posedge hclk);
  endtask
  // Pipeline contents no longer predictable after a change
  task cfg;
    q.delete();
    skip = 20;
  endtask
  task recal;
    cfg();
    ahb(1'b1, 32'(REG_CTRL), 32'h1);
    ahb(1'b0, 32'(REG_STATUS), 32'h0);
    chk(r[2:0] & 3'h5, 3'h5);
    wcal(1'b1);
    wcal(1'b0);
  endtask

  // ----------------
  // Stimulus and model
  // ----------------
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Cores get disjoint ranges so a word names its core
  // Seeded here, since each process draws from its own generator
  initial begin
    void'($urandom(87));
    {analog_a, analog_b, over_a, over_b} = '0;
    forever begin
      @(posedge hclk);
      ov = ovf | ($urandom % 16 == 0);
      analog_a <= 12'($urandom % 1024);
      analog_b <= 12'(1024 + $urandom % 1024);
      over_a <= ov;
      over_b <= ov;
    end
  end
  // Model sees inputs as they stood at the last edge
  always @(negedge hclk) begin
    gap++;
    if (!hresetn || lk.calibration_reset_low !== 1'b1) cfg();
    if (calibrating === 1'b1) chk(lk.over_range_p, 1);
    if (lk.output_clock !== pclk) begin
      q.push_back({pov, pa, 12'(pb + (pb * sp_gain_b) / 256 + sp_offset_b)});
      if (q.size() > 15) begin
        e = q.pop_front();
        w = lk.sample_data >= 12'h400;
        if (skip == 0) begin
          chk(lk.sample_data, w ? e[11:0] : e[23:12]);
          chk(w, !lw);
          chk(gap, exp_div);
          if (!calibrating && !pc) chk(lk.over_range_p, e[24]);
        end
        lw = w;
      end
      if (skip > 0) skip--;
      gap = 0;
    end
    pclk = lk.output_clock;
    pa = analog_a;
    // Core B passes one register stage plus the chosen skew tap
    for (int i = 4; i > 0; i--) hb[i] = hb[i-1];
    hb[0] = analog_b;
    pb = hb[sp_skew_b + 1];
    pov = over_a;
    pc = calibrating;
  end

  initial begin
    {hresetn, hsel, hwrite, htrans, hsize, haddr, hwdata, sp_recal, sp_skew_b} = '0;
    {sp_div_override, sp_div_by2, sp_mode_override, sp_mode, sp_gain_b, sp_offset_b} = '0;
    ovf = 1'b0;
    divider_strap = STRAP_FLOAT;
    output_mode_strap = STRAP_FLOAT;
    exp_div = 1;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    wcal(1'b1);
    chk(lk.calibration_reset_low, 1);
    wcal(1'b0);
    chk(init_done, 1);
    chk(lk.output_mode, MODE_LVDS_3MA);
    repeat (80) @(posedge hclk);
    ahb(1'b1, 32'h10, 32'hffff);
    ahb(1'b0, 32'h10, 32'h0);
    chk(r, 0);
    // A write outside the map must not start a recalibration pulse
    ahb(1'b0, 32'(REG_STATUS), 32'h0);
    chk(r[2:0] & 3'h5, 3'h0);
    for (int i = 0; i < 3; i++) begin
      output_mode_strap <= i[1:0];
      divider_strap <= (i == 1) ? STRAP_FLOAT : STRAP_LOW;
      exp_div = (i == 1) ? 1 : 2;
      recal();
      chk(lk.output_mode, i[1:0]);
      output_mode_strap <= 2'((i + 1) % 3);
      repeat (80) @(posedge hclk);
      chk(lk.output_mode, i[1:0]);
      ahb(1'b0, 32'(REG_SAMPLE), 32'h0);
      chk((r[11:0] >= 12'h400) ^ (r[27:16] >= 12'h400), 1);
    end
    // Overrides beat the latched straps at once
    sp_div_override <= 1'b1;
    sp_mode_override <= 1'b1;
    sp_mode <= MODE_CMOS;
    sp_gain_b <= 8'h10;
    sp_offset_b <= 8'h07;
    sp_skew_b <= 2'h2;
    exp_div = 1;
    cfg();
    repeat (4) @(posedge hclk);
    chk(lk.output_mode, MODE_CMOS);
    repeat (100) @(posedge hclk);
    // Divide by one: a word every cycle, so the capture beats the clear
    ahb(1'b1, 32'(REG_COUNT), 32'h0);
    ahb(1'b0, 32'(REG_COUNT), 32'h0);
    chk(r, 1);
    sp_div_by2 <= 1'b1;
    exp_div = 2;
    cfg();
    repeat (100) @(posedge hclk);
    ovf = 1'b1;
    sp_recal <= 1'b1;
    @(posedge hclk);
    sp_recal <= 1'b0;
    wcal(1'b1);
    wcal(1'b0);
    repeat (3) @(posedge hclk);
    chk(lk.over_range_p, 1);
    ovf = 1'b0;
    repeat (60) @(posedge hclk);
    chk(calibrating, 0);
    stop_test();
  end
endmodule // tb_top

// *** src/adc_capture_end.sv ***
`timescale 1ns/1ps
module adc_capture_end
  import adc_link_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  adc_link_if.capture link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  import adc_link_pkg::*;

  typedef struct packed {
    logic wr_pend;
    logic [3:0] wr_addr;
    logic [31:0] rdata;
    logic [7:0] hold_cnt;
    logic host_oe;
    logic clk_prev;
    logic [SAMPLE_W-1:0] rise_word;
    logic [SAMPLE_W-1:0] fall_word;
    logic [15:0] count;
  } cap_state_t;

  cap_state_t state;
  cap_state_t next_state;
  logic take;
  logic mapped;
  logic clr_count;
  logic [31:0] status;

  // ----------------------------------------------------------------
  // Bus slave, capture and recalibration pulse
  // ----------------------------------------------------------------
  // Link signals come from logic on hclk, so no synchroniser here
  always_comb begin
    next_state = state;
    take = hsel & hready & (htrans == HTRANS_NONSEQ);
    mapped = (haddr[31:4] == 28'h0000000);
    clr_count = state.wr_pend & (state.wr_addr == REG_COUNT);
    status = '0;
    status[STAT_LINE_LOW_BIT] = ~link.calibration_reset_low;
    status[STAT_OVER_BIT] = link.over_range_p;
    status[STAT_RECAL_BIT] = state.host_oe;

    // Only the low words decode; anything above is a hole, not an alias
    next_state.wr_pend = take & hwrite & mapped;
    next_state.wr_addr = haddr[3:0];
    if (take & ~hwrite & ~mapped) begin
      next_state.rdata = '0;
    end else if (take & ~hwrite) begin
      case (haddr[3:0])
        REG_STATUS: next_state.rdata = status;
        REG_SAMPLE: next_state.rdata = {4'h0, state.fall_word, 4'h0, state.rise_word};
        REG_COUNT: next_state.rdata = {16'h0000, state.count};
        default: next_state.rdata = '0;
      endcase
    end

    // Line is only ever pulled low, never driven high
    if (state.wr_pend & (state.wr_addr == REG_CTRL) & hwdata[CTRL_RECAL_BIT]) begin
      next_state.hold_cnt = 8'(RECAL_HOLD_CYC);
      next_state.host_oe = 1'b1;
    end else if (state.hold_cnt > 8'h01) begin
      next_state.hold_cnt = state.hold_cnt - 1'b1;
    end else begin
      next_state.hold_cnt = '0;
      next_state.host_oe = 1'b0;
    end

    // Word on each output clock edge; a capture beats a count clear
    next_state.clk_prev = link.output_clock;
    if (link.output_clock != state.clk_prev) begin
      if (link.output_clock) begin
        next_state.rise_word = link.sample_data;
      end else begin
        next_state.fall_word = link.sample_data;
      end
      next_state.count = clr_count ? 16'h0001 : state.count + 1'b1;
    end else if (clr_count) begin
      next_state.count = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = state.rdata;
  assign link.cal_host_out = 1'b0;
  assign link.cal_host_oe = state.host_oe;
endmodule // adc_capture_end

// *** src/adc_device_end.sv ***
`timescale 1ns/1ps
module adc_device_end
  import adc_link_pkg::*;
#(
  parameter int POR_CYCLES = 16,
  parameter int CAL_CYCLES = 8192
) (
  input wire logic hclk,
  input wire logic hresetn,
  adc_link_if.device link,
  input wire logic [adc_link_pkg::SAMPLE_W-1:0] analog_a,
  input wire logic [adc_link_pkg::SAMPLE_W-1:0] analog_b,
  input wire logic over_a,
  input wire logic over_b,
  input wire logic [1:0] divider_strap,
  input wire logic [1:0] output_mode_strap,
  input wire logic sp_div_override,
  input wire logic sp_div_by2,
  input wire logic sp_mode_override,
  input wire logic [1:0] sp_mode,
  input wire logic sp_recal,
  input wire logic [7:0] sp_gain_b,
  input wire logic [7:0] sp_offset_b,
  input wire logic [1:0] sp_skew_b,
  output logic calibrating,
  output logic init_done
);
  import adc_link_pkg::*;

  localparam int CW = $clog2(CAL_CYCLES + 1);
  localparam int PW = $clog2(POR_CYCLES + 1);

  typedef struct packed {
    logic line_s1;
    logic line_s2;
    logic line_prev;
    logic [PW-1:0] por_cnt;
    logic por_drive;
    logic cal_busy;
    logic [CW-1:0] cal_cnt;
    logic init_done;
    logic div_phase;
    logic core_sel;
    logic [SKEW_DEPTH-1:0][SAMPLE_W:0] skew_line;
    logic [LATENCY-1:0][SAMPLE_W:0] pipe;
    logic over_norm;
    logic [SAMPLE_W-1:0] data_out;
    logic clk_out;
    logic or_p;
    logic or_n;
    logic [1:0] mode;
  } dev_state_t;

  dev_state_t state;
  dev_state_t next_state;
  logic cal_start;
  logic [1:0] div_level;
  logic [1:0] mode_level;

  // ----------------------------------------------------------------
  // Strap decoders, captured when calibration starts
  // ----------------------------------------------------------------
  strap_decoder u_div_strap (
    .hclk(hclk),
    .hresetn(hresetn),
    .strap_pin(divider_strap),
    .capture(cal_start),
    .strap_level(div_level)
  );

  strap_decoder u_mode_strap (
    .hclk(hclk),
    .hresetn(hresetn),
    .strap_pin(output_mode_strap),
    .capture(cal_start),
    .strap_level(mode_level)
  );

  // ----------------------------------------------------------------
  // Core B correction: skew delay, gain, offset, saturation
  // ----------------------------------------------------------------
  logic [SAMPLE_W:0] b_raw;
  logic signed [21:0] b_x;
  logic signed [21:0] gain_x;
  logic signed [21:0] off_x;
  logic signed [43:0] prod;
  logic signed [21:0] b_sum;
  logic [SAMPLE_W-1:0] b_corr;

  always_comb begin
    b_raw = state.skew_line[sp_skew_b];
    b_x = $signed({10'h000, b_raw[SAMPLE_W-1:0]});
    gain_x = $signed({{14{sp_gain_b[7]}}, sp_gain_b});
    off_x = $signed({{14{sp_offset_b[7]}}, sp_offset_b});
    prod = b_x * gain_x;
    b_sum = b_x + prod[29:8] + off_x;
    if (b_sum < 0) begin
      b_corr = '0;
    end else if (b_sum > $signed({10'h000, SAMPLE_MAX})) begin
      b_corr = SAMPLE_MAX;
    end else begin
      b_corr = b_sum[SAMPLE_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Calibration, conversion clock, pipeline and outputs
  // ----------------------------------------------------------------
  logic line_low;
  logic div_by2;
  logic conv_tick;
  logic [SAMPLE_W:0] new_word;

  always_comb begin
    next_state = state;
    line_low = ~state.line_s2;
    // Serial command is ignored until the power-on calibration is over
    cal_start = (state.line_s2 & ~state.line_prev) |
                (sp_recal & state.init_done & ~state.cal_busy);
    div_by2 = sp_div_override ? sp_div_by2 : (div_level == STRAP_LOW);
    conv_tick = div_by2 ? state.div_phase : 1'b1;
    new_word = state.core_sel ? {over_b, b_corr} : {over_a, analog_a};

    // Reset line: two flops before any use
    next_state.line_s1 = link.calibration_reset_low;
    next_state.line_s2 = state.line_s1;
    next_state.line_prev = state.line_s2;

    // Internal supply detector holds the line low, then lets go
    if (state.por_drive) begin
      if (state.por_cnt == PW'(POR_CYCLES - 1)) begin
        next_state.por_drive = 1'b0;
      end
      next_state.por_cnt = state.por_cnt + 1'b1;
    end

    if (cal_start) begin
      next_state.cal_busy = 1'b1;
      next_state.cal_cnt = '0;
    end else if (state.cal_busy) begin
      if (state.cal_cnt == CW'(CAL_CYCLES - 1)) begin
        next_state.cal_busy = 1'b0;
        next_state.init_done = 1'b1;
      end else begin
        next_state.cal_cnt = state.cal_cnt + 1'b1;
      end
    end

    // Skew history of core B runs every cycle
    next_state.skew_line[0] = {over_b, analog_b};
    for (int i = 1; i < SKEW_DEPTH; i++) begin
      next_state.skew_line[i] = state.skew_line[i-1];
    end

    next_state.div_phase = ~state.div_phase;
    if (conv_tick) begin
      next_state.core_sel = ~state.core_sel;
      next_state.pipe[0] = new_word;
      for (int i = 1; i < LATENCY; i++) begin
        next_state.pipe[i] = state.pipe[i-1];
      end
      // No word leaves while the output clock is frozen, so data never moves alone
      if (!line_low) begin
        next_state.data_out = state.pipe[LATENCY-1][SAMPLE_W-1:0];
        next_state.over_norm = state.pipe[LATENCY-1][SAMPLE_W];
      end
    end

    // One data word per output clock edge; frozen low while line low
    if (line_low) begin
      next_state.clk_out = 1'b0;
    end else if (conv_tick) begin
      next_state.clk_out = ~state.clk_out;
    end

    next_state.mode = sp_mode_override ? sp_mode : mode_level;
    // Over-range forced during calibration; real overflow still shows
    next_state.or_p = line_low | next_state.cal_busy | next_state.over_norm;
    next_state.or_n = (next_state.mode != MODE_CMOS) & ~next_state.or_p;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '0;
      state.por_drive <= 1'b1;
      state.or_p <= 1'b1;
      state.mode <= MODE_LVDS_3MA;
    end else begin
      state <= next_state;
    end
  end

  assign link.cal_dev_out = 1'b0;
  assign link.cal_dev_oe = state.por_drive;
  assign link.sample_data = state.data_out;
  assign link.output_clock = state.clk_out;
  assign link.over_range_p = state.or_p;
  assign link.over_range_n = state.or_n;
  assign link.output_mode = state.mode;
  assign calibrating = state.cal_busy;
  assign init_done = state.init_done;
endmodule // adc_device_end

// *** src/adc_link_if.sv ***
`timescale 1ns/1ps
interface adc_link_if;
  import adc_link_pkg::*;
  logic cal_dev_out;
  logic cal_dev_oe;
  logic cal_host_out;
  logic cal_host_oe;
  logic calibration_reset_low;
  logic [SAMPLE_W-1:0] sample_data;
  logic output_clock;
  logic over_range_p;
  logic over_range_n;
  logic [1:0] output_mode;

  // Open-drain line with pull-up
  assign calibration_reset_low = (cal_dev_oe ? cal_dev_out : 1'b1) &
                                 (cal_host_oe ? cal_host_out : 1'b1);

  modport device (input calibration_reset_low, output cal_dev_out, output cal_dev_oe,
    output sample_data, output output_clock, output over_range_p, output over_range_n,
    output output_mode);
  modport capture (input calibration_reset_low, output cal_host_out, output cal_host_oe,
    input sample_data, input output_clock, input over_range_p, input over_range_n,
    input output_mode);
endinterface

// *** src/adc_link_pkg.sv ***
// Behaviour
// - Result appears fifteen conversion cycles after start
// - Two cores sample on alternate clock phases
// - Calibration starts on reset line rising edge
// - Over-range high from line low to calibration end
// - Over-range input keeps flag high after calibration
// - Output clock held low while line low
// - Output clock resumes on next conversion edge
// - Recalibration pulls line low 20 ns (four cycles) minimum
// - Serial recalibration accepted after initial calibration
// - Stable clock, no serial traffic during calibration
// - Serial data output never held low at power-up
// - Far end never forces reset line high
// - Divider strap: low halves, float passes, high illegal
// - Serial divide setting overrides divider strap
// - Mode strap: low CMOS, float 3mA, high 2mA
// - Serial output mode overrides mode strap
// - Samples on both output clock edges
// - Gain, offset, skew correction between cores
// - Separate over-range output, pair or single line
package adc_link_pkg;
  // ----------------------------------------------------------------
  // Tri-level strap codes and output modes
  // ----------------------------------------------------------------
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  localparam logic [1:0] MODE_CMOS = 2'h0;
  localparam logic [1:0] MODE_LVDS_3MA = 2'h1;
  localparam logic [1:0] MODE_LVDS_2MA = 2'h2;
  localparam logic [1:0] STRAP_RESET = STRAP_FLOAT;

  // ----------------------------------------------------------------
  // Datapath and timing
  // ----------------------------------------------------------------
  localparam int SAMPLE_W = 12;
  localparam int LATENCY = 15;
  localparam int SKEW_DEPTH = 4;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RECAL_HOLD_NS = 20;
  localparam int RECAL_HOLD_CYC = (RECAL_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [11:0] SAMPLE_MAX = 12'hfff;

  // ----------------------------------------------------------------
  // Capture-end register map and bus codes
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_SAMPLE = 4'h8;
  localparam logic [3:0] REG_COUNT = 4'hc;
  localparam int CTRL_RECAL_BIT = 0;
  localparam int STAT_LINE_LOW_BIT = 0;
  localparam int STAT_OVER_BIT = 1;
  localparam int STAT_RECAL_BIT = 2;
  localparam int SAMPLE_FALL_LSB = 16;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
endpackage

// *** src/strap_decoder.sv ***
`timescale 1ns/1ps
module strap_decoder
  import adc_link_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [1:0] strap_pin,
  input wire logic capture,
  output logic [1:0] strap_level
);
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] level;
  } strap_state_t;

  strap_state_t state;
  strap_state_t next_state;

  // Pin passes two flops; level is frozen at calibration start
  always_comb begin
    next_state = state;
    next_state.sync1 = strap_pin;
    next_state.sync2 = state.sync1;
    if (capture) begin
      next_state.level = state.sync2;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= '{sync1: STRAP_RESET, sync2: STRAP_RESET, level: STRAP_RESET};
    end else begin
      state <= next_state;
    end
  end

  assign strap_level = state.level;
endmodule // strap_decoder
